/* File: rtl/aocfg_regs.vh */
// Register map, field positions and reset values for the analog output configuration block.
// Assumes byte offsets from the board base address on a 16-bit host write port.
`ifndef AOCFG_REGS_VH
`define AOCFG_REGS_VH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define AOCFG_ADDR_W            5
`define AOCFG_OFS_CONFIG        5'h16
`define AOCFG_OFS_FIFO_DATA     5'h1E
`define AOCFG_OFS_DIRECT0       5'h18
`define AOCFG_OFS_DIRECT1       5'h1A

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AOCFG_BIT_TARGET        8
`define AOCFG_BIT_GROUND        3
`define AOCFG_BIT_EXTERNAL_REFERENCE_SELECT        2
`define AOCFG_BIT_GLITCH        1
`define AOCFG_BIT_BIPOLAR       0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define AOCFG_RST_SETTINGS      3'h0
`define AOCFG_RST_GROUND        1'h0
`define AOCFG_RST_DATA          16'h0000

`endif

/* File: rtl/aocfg_conv_settings.v */
// One converter's copy of the reference, glitch and polarity settings.
// Assumes the parent decodes the configuration write and the target bit.
`timescale 1ns/1ns
module aocfg_conv_settings (
   input  wire       clk_in,
   input  wire       rst_in,
   input  wire       load_in,
   input  wire [2:0] settings_in,
   output wire       external_reference_select_out,
   output wire       uniform_glitch_out,
   output wire       bipolar_output_mode_out
);
`include "aocfg_regs.vh"

   reg  [2:0] settings_ff;
   wire [2:0] nxt_settings;

   // Untargeted copy holds its value
   assign nxt_settings = load_in ? settings_in : settings_ff;

   always @(posedge clk_in) begin
      if (rst_in) begin
         settings_ff <= `AOCFG_RST_SETTINGS;
      end else begin
         settings_ff <= nxt_settings;
      end
   end

   assign external_reference_select_out = settings_ff[2];
   assign uniform_glitch_out            = settings_ff[1];
   assign bipolar_output_mode_out       = settings_ff[0];
endmodule

/* File: rtl/aocfg_top.v */
// Analog output configuration register and the two converter data paths.
// Assumes a synchronous 16-bit write-only host port; writes are one-cycle strobes.
`timescale 1ns/1ns

// Functional notes
// - Write-only 16-bit config register at 0x16
// - Reset clears every stored setting
// - Bit 8 picks first or second converter
// - Bit 3 shared, grounds both references
// - Bit 2 external or internal reference
// - Bit 1 uniform-glitch mode per converter
// - Data direct, or through FIFO path for first converter only
// - Bit 0 bipolar two's complement, else unipolar
module aocfg_top (
   input  wire        clk_in,
   input  wire        rst_in,
   input  wire        wr_en_in,
   input  wire [4:0]  addr_in,
   input  wire [15:0] wr_data_in,
   input  wire        rd_en_in,
   output wire [15:0] rd_data_out,
   output wire        fifo_wr_valid_out,
   output wire [15:0] fifo_wr_data_out,
   input  wire        fifo_full_in,
   input  wire        fifo_rd_valid_in,
   input  wire [15:0] fifo_rd_data_in,
   output wire        fifo_rd_ready_out,
   output wire [15:0] first_converter_data_out,
   output wire [15:0] second_converter_data_out,
   output wire        reference_grounding_out,
   output wire        first_converter_external_reference_select_out,
   output wire        first_converter_glitch_out,
   output wire        first_converter_bipolar_out,
   output wire        second_converter_external_reference_select_out,
   output wire        second_converter_glitch_out,
   output wire        second_converter_bipolar_out
);
`include "aocfg_regs.vh"

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function hit;
      input [4:0] addr;
      input [4:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   // One select per decoded offset; other offsets are ignored
   wire cfg_wr;
   wire dir0_wr;
   wire dir1_wr;
   wire fifo_wr;

   assign cfg_wr  = wr_en_in & hit(addr_in, `AOCFG_OFS_CONFIG);
   assign dir0_wr = wr_en_in & hit(addr_in, `AOCFG_OFS_DIRECT0);
   assign dir1_wr = wr_en_in & hit(addr_in, `AOCFG_OFS_DIRECT1);
   assign fifo_wr = wr_en_in & hit(addr_in, `AOCFG_OFS_FIFO_DATA);

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   // Write-only: reads return zero, not register contents
   // The read strobe is taken but has nothing to fetch
   assign rd_data_out = 16'h0000;

   // ----------------------------------------
   // Configuration fields
   // ----------------------------------------
   // Reserved bits 15-9 and 7-4 are not stored
   wire       target_second = wr_data_in[`AOCFG_BIT_TARGET];
   wire [2:0] wr_settings   = {wr_data_in[`AOCFG_BIT_EXTERNAL_REFERENCE_SELECT],
                               wr_data_in[`AOCFG_BIT_GLITCH],
                               wr_data_in[`AOCFG_BIT_BIPOLAR]};

   // ----------------------------------------
   // Shared reference grounding
   // ----------------------------------------
   // Stored once, so the two converters cannot be grounded apart
   reg  reference_grounding_ff;
   reg  nxt_reference_grounding;

   // Shared bit: last write wins, whatever the target
   always @* begin
      nxt_reference_grounding = reference_grounding_ff;
      if (cfg_wr) begin
         nxt_reference_grounding = wr_data_in[`AOCFG_BIT_GROUND];
      end
   end

   always @(posedge clk_in) begin
      if (rst_in) begin
         reference_grounding_ff <= `AOCFG_RST_GROUND;
      end else begin
         reference_grounding_ff <= nxt_reference_grounding;
      end
   end

   assign reference_grounding_out = reference_grounding_ff;

   // ----------------------------------------
   // Per-converter copies
   // ----------------------------------------
   reg  [1:0] conv_load;
   wire [1:0] conv_external_reference_select;
   wire [1:0] conv_glitch;
   wire [1:0] conv_bipolar;

   // Target bit steers the load to exactly one copy
   always @* begin
      case (target_second)
         1'h0: begin
            conv_load = {1'h0, cfg_wr};
         end
         1'h1: begin
            conv_load = {cfg_wr, 1'h0};
         end
         default: begin
            conv_load = 2'h0;
         end
      endcase
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_conv
         aocfg_conv_settings u_settings (
            .clk_in                        (clk_in),
            .rst_in                        (rst_in),
            .load_in                       (conv_load[gi]),
            .settings_in                   (wr_settings),
            .external_reference_select_out (conv_external_reference_select[gi]),
            .uniform_glitch_out            (conv_glitch[gi]),
            .bipolar_output_mode_out       (conv_bipolar[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // Output mapping
   // ----------------------------------------
   // Settings reach the converters straight from the copies
   assign first_converter_external_reference_select_out   = conv_external_reference_select[0];
   assign first_converter_glitch_out   = conv_glitch[0];
   assign first_converter_bipolar_out  = conv_bipolar[0];
   assign second_converter_external_reference_select_out  = conv_external_reference_select[1];
   assign second_converter_glitch_out  = conv_glitch[1];
   assign second_converter_bipolar_out = conv_bipolar[1];

   // ----------------------------------------
   // FIFO push
   // ----------------------------------------
   // FIFO words feed the first converter; the FIFO itself is outside
   // A write while full is dropped; the host must watch the full flag
   wire fifo_push;

   assign fifo_push         = fifo_wr & ~fifo_full_in;
   assign fifo_wr_valid_out = fifo_push;
   assign fifo_wr_data_out  = wr_data_in;

   // ----------------------------------------
   // FIFO drain
   // ----------------------------------------
   // Direct write takes the cycle, so FIFO drain waits behind it
   wire drain_ready;
   wire fifo_drain;

   assign drain_ready       = ~dir0_wr;
   assign fifo_drain        = fifo_rd_valid_in & drain_ready;
   assign fifo_rd_ready_out = drain_ready;

   // ----------------------------------------
   // First converter data
   // ----------------------------------------
   // Direct write beats a FIFO word in the same cycle
   reg  [15:0] conv0_data_ff;
   reg  [15:0] nxt_conv0_data;

   always @* begin
      nxt_conv0_data = conv0_data_ff;
      if (dir0_wr) begin
         nxt_conv0_data = wr_data_in;
      end else if (fifo_drain) begin
         nxt_conv0_data = fifo_rd_data_in;
      end
   end

   always @(posedge clk_in) begin
      if (rst_in) begin
         conv0_data_ff <= `AOCFG_RST_DATA;
      end else begin
         conv0_data_ff <= nxt_conv0_data;
      end
   end

   assign first_converter_data_out = conv0_data_ff;

   // ----------------------------------------
   // Second converter data
   // ----------------------------------------
   // Direct path only; the FIFO never feeds this converter
   reg  [15:0] conv1_data_ff;
   reg  [15:0] nxt_conv1_data;

   always @* begin
      nxt_conv1_data = conv1_data_ff;
      if (dir1_wr) begin
         nxt_conv1_data = wr_data_in;
      end
   end

   always @(posedge clk_in) begin
      if (rst_in) begin
         conv1_data_ff <= `AOCFG_RST_DATA;
      end else begin
         conv1_data_ff <= nxt_conv1_data;
      end
   end

   assign second_converter_data_out = conv1_data_ff;
endmodule

/* File: tb/aocfg_chk.sv */
// Checker for the analog output configuration block.
// Assumes a bind onto aocfg_top and a single clock domain.
`timescale 1ns/1ns
module aocfg_chk (
   input wire        clk_in,
   input wire        rst_in,
   input wire        wr_en_in,
   input wire [4:0]  addr_in,
   input wire [15:0] wr_data_in,
   input wire        fifo_full_in,
   input wire        fifo_rd_valid_in,
   input wire [15:0] fifo_rd_data_in,
   input wire [15:0] rd_data_out,
   input wire        fifo_wr_valid_out,
   input wire [15:0] fifo_wr_data_out,
   input wire        fifo_rd_ready_out,
   input wire [15:0] first_converter_data_out,
   input wire [15:0] second_converter_data_out,
   input wire        reference_grounding_out,
   input wire        first_converter_external_reference_select_out,
   input wire        first_converter_glitch_out,
   input wire        first_converter_bipolar_out,
   input wire        second_converter_external_reference_select_out,
   input wire        second_converter_glitch_out,
   input wire        second_converter_bipolar_out
);
// ----------------------------------------
// Properties
// ----------------------------------------
   wire [2:0] s0 = {first_converter_external_reference_select_out, first_converter_glitch_out,
                    first_converter_bipolar_out};
   wire [2:0] s1 = {second_converter_external_reference_select_out, second_converter_glitch_out,
                    second_converter_bipolar_out};
   wire cfg = wr_en_in && addr_in == 5'h16;
   wire l0  = cfg && !wr_data_in[8];
   wire l1  = cfg && wr_data_in[8];
   wire d0w = wr_en_in && addr_in == 5'h18;
   wire d1w = wr_en_in && addr_in == 5'h1A;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   sequence s_pair; l0 ##1 l1; endsequence
   a_read_zero: assert property (rd_data_out == 16'h0000)
      else $error("read data not zero");
   a_reset_clear: assert property (disable iff (1'b0) rst_in |=>
      s0 == 3'h0 && s1 == 3'h0 && !reference_grounding_out &&
      first_converter_data_out == 16'h0000 && second_converter_data_out == 16'h0000)
      else $error("reset left state");
   a_first_load: assert property (l0 |=> s0 == $past(wr_data_in[2:0]))
      else $error("first copy not loaded");
   a_second_load: assert property (l1 |=> s1 == $past(wr_data_in[2:0]))
      else $error("second copy not loaded");
   a_ground_shared: assert property (cfg |=> reference_grounding_out == $past(wr_data_in[3]))
      else $error("grounding bit wrong");
   a_first_keep: assert property (!l0 |=> $stable(s0))
      else $error("first copy disturbed");
   a_second_keep: assert property (!l1 |=> $stable(s1))
      else $error("second copy disturbed");
   a_pair_split: assert property (s_pair |=> s0 == $past(wr_data_in[2:0], 2))
      else $error("back to back writes mixed");
   a_direct_load: assert property (wr_en_in && addr_in == 5'h18 |=>
      first_converter_data_out == $past(wr_data_in)) else $error("direct word lost");
   a_fifo_push: assert property (fifo_wr_valid_out ==
      (wr_en_in && addr_in == 5'h1E && !fifo_full_in)) else $error("fifo push wrong");
   a_second_direct: assert property (d1w |=>
      second_converter_data_out == $past(wr_data_in)) else $error("second direct word lost");
   a_drain_load: assert property (fifo_rd_valid_in && !d0w |=>
      first_converter_data_out == $past(fifo_rd_data_in)) else $error("fifo word lost");
   a_drain_ready: assert property (fifo_rd_ready_out == !d0w)
      else $error("drain ready wrong");
   a_fifo_data: assert property (fifo_wr_valid_out |-> fifo_wr_data_out == wr_data_in)
      else $error("fifo data wrong");
   a_first_hold: assert property (!d0w && !fifo_rd_valid_in |=>
      $stable(first_converter_data_out)) else $error("first data disturbed");
   a_second_hold: assert property (!d1w |=> $stable(second_converter_data_out))
      else $error("second data disturbed");
endmodule
bind aocfg_top aocfg_chk i_aocfg_chk (
   .clk_in                       (clk_in),
   .rst_in                       (rst_in),
   .wr_en_in                     (wr_en_in),
   .addr_in                      (addr_in),
   .wr_data_in                   (wr_data_in),
   .fifo_full_in                 (fifo_full_in),
   .fifo_rd_valid_in             (fifo_rd_valid_in),
   .fifo_rd_data_in              (fifo_rd_data_in),
   .rd_data_out                  (rd_data_out),
   .fifo_wr_valid_out            (fifo_wr_valid_out),
   .fifo_wr_data_out             (fifo_wr_data_out),
   .fifo_rd_ready_out            (fifo_rd_ready_out),
   .first_converter_data_out     (first_converter_data_out),
   .second_converter_data_out    (second_converter_data_out),
   .reference_grounding_out      (reference_grounding_out),
   .first_converter_external_reference_select_out   (first_converter_external_reference_select_out),
   .first_converter_glitch_out   (first_converter_glitch_out),
   .first_converter_bipolar_out  (first_converter_bipolar_out),
   .second_converter_external_reference_select_out  (second_converter_external_reference_select_out),
   .second_converter_glitch_out  (second_converter_glitch_out),
   .second_converter_bipolar_out (second_converter_bipolar_out)
);

/* File: tb/aocfg_top_tb.sv */
// Random write bench for the analog output configuration block.
// Assumes writes are one strobe per cycle; the drain valid is randomised on write and reset cycles.
`timescale 1ns/1ns
module aocfg_top_tb;
// ----------------------------------------
// Drive and watch
// ----------------------------------------
   reg         clk_in = 1'b0;
   reg         rst_in = 1'b1;
   reg         wr_en_in = 1'b0;
   reg  [4:0]  addr_in = 5'h00;
   reg  [15:0] wr_data_in = 16'h0000;
   reg         fifo_full_in = 1'b0;
   reg         rd_en_in = 1'h0;
   reg         fifo_rd_valid_in = 1'h0;
   reg  [15:0] fifo_rd_data_in = 16'h0000;
   reg         vld_ff = 1'h0;
   reg         chk_ff = 1'b0;
   reg  [38:0] exp_v = 39'h0;
   reg  [38:0] want;
   reg  [38:0] notes [$];
   reg  [31:0] r32;
   reg  [4:0]  amap [0:3];
   integer     seed = 69;
   integer     num_errors = 0;
   integer     checks_done = 0;
   integer     i;
   wire [6:0]  st;
   wire [15:0] d0, d1;
   aocfg_top i_aocfg_top (.clk_in(clk_in), .rst_in(rst_in), .wr_en_in(wr_en_in),
      .addr_in(addr_in), .wr_data_in(wr_data_in), .rd_en_in(rd_en_in), .rd_data_out(),
      .fifo_wr_valid_out(), .fifo_wr_data_out(), .fifo_full_in(fifo_full_in),
      .fifo_rd_valid_in(fifo_rd_valid_in), .fifo_rd_data_in(fifo_rd_data_in),
      .fifo_rd_ready_out(),
      .first_converter_data_out(d0), .second_converter_data_out(d1),
      .reference_grounding_out(st[6]), .second_converter_external_reference_select_out(st[5]),
      .second_converter_glitch_out(st[4]), .second_converter_bipolar_out(st[3]),
      .first_converter_external_reference_select_out(st[2]), .first_converter_glitch_out(st[1]),
      .first_converter_bipolar_out(st[0]));
   initial forever #5 clk_in = ~clk_in;
   // Result of a noted request is settled on the same edge that samples it
   always @(posedge clk_in) chk_ff <= vld_ff;
   always @(negedge clk_in) begin
      if (chk_ff && notes.size() > 0) begin
         want = notes.pop_front();
         checks_done = checks_done + 1;
         if ({st, d0, d1} !== want) begin
            num_errors = num_errors + 1;
            $display("ERROR outputs expected %h seen %h", want, {st, d0, d1});
         end
      end
   end
   task go(input [4:0] a, input [15:0] d, input w, input r);
      @(posedge clk_in);
      r32 = $random(seed);
      wr_en_in <= w;
      rst_in <= r;
      addr_in <= a;
      wr_data_in <= d;
      fifo_full_in <= r32[0];
      rd_en_in <= r32[2];
      fifo_rd_valid_in <= r32[1] & (w | r);
      fifo_rd_data_in <= r32[31:16];
      vld_ff <= w | r;
      if (r) exp_v = 39'h0;
      else if (w && a == 5'h16) begin
         exp_v[38] = d[3];
         if (d[8]) exp_v[37:35] = d[2:0];
         else exp_v[34:32] = d[2:0];
      end
      else if (w && a == 5'h18) exp_v[31:16] = d;
      else if (w && a == 5'h1A) exp_v[15:0] = d;
      if (!r && w && r32[1] && a != 5'h18) exp_v[31:16] = r32[31:16];
      if (w | r) notes.push_back(exp_v);
   endtask
   task end_sim;
      if (num_errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      amap[0] = 5'h16; amap[1] = 5'h18; amap[2] = 5'h1A; amap[3] = 5'h1E;
      repeat (3) @(posedge clk_in);
      go(5'h00, 16'h0000, 1'b0, 1'b1);
      for (i = 0; i < 300; i = i + 1) begin
         r32 = $random(seed);
         if (i == 150) go(5'h00, 16'h0000, 1'b0, 1'b1);
         // Only the defined config bits are set; reserved ones stay zero
         if (amap[r32[17:16]] == 5'h16) go(5'h16, r32[15:0] & 16'h010F, 1'b1, 1'b0);
         else go(amap[r32[17:16]], r32[15:0], 1'b1, 1'b0);
      end
      go(5'h00, 16'h0000, 1'b0, 1'b0);
      for (i = 0; i < 10 && notes.size() > 0; i = i + 1) @(posedge clk_in);
      if (notes.size() > 0) begin
         num_errors = num_errors + 1;
         $display("ERROR pending notes expected 0 seen %0d", notes.size());
      end
      end_sim;
   end
endmodule
